// ### ocpwm_pkg.sv
// Purpose: Shared constants and types for the compare/PWM channel
// Assumes: 32-bit AHB-Lite register bus, 16-bit channel registers
// Notes: Offsets are byte addresses of aligned words
package ocpwm_pkg;
   // ********************************
   // Register map
   // ********************************
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_PRIMARY = 8'h04;
   localparam logic [7:0] OFS_SECONDARY = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0c;
   localparam logic [7:0] OFS_CTRL_AUX = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_COUNTER = 8'h18;
   // ********************************
   // Control field positions
   // ********************************
   localparam int POS_IDLE_STOP = 13;
   localparam int POS_TSEL = 10;
   localparam int POS_EN_CMP = 9;
   localparam int POS_EN_PINB = 8;
   localparam int POS_EN_PINA = 7;
   localparam int POS_ST_CMP = 6;
   localparam int POS_ST_PINB = 5;
   localparam int POS_ST_PINA = 4;
   localparam int POS_TRIG_MODE = 3;
   localparam int POS_HOLD_MODE = 1;
   localparam int POS_DRIVE_LEVEL = 0;
   localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
   localparam logic [15:0] CTRL_ONE_MASK = 16'h3fff;
   // ********************************
   // Time base selections and bus constants
   // ********************************
   localparam logic [2:0] TSEL_T1 = 3'h4;
   localparam logic [2:0] TSEL_FCY = 3'h7;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] IDENT_VALUE = 32'h0000_0000; // Arbitrary value
   // Output compare modes
   typedef enum logic [2:0] {
      OCPWM_OFF = 3'b000,
      OCPWM_SS_HIGH = 3'b001,
      OCPWM_SS_LOW = 3'b010,
      OCPWM_TOGGLE = 3'b011,
      OCPWM_DBL_SHOT = 3'b100,
      OCPWM_DBL_CONT = 3'b101,
      OCPWM_EDGE = 3'b110,
      OCPWM_CENTER = 3'b111
   } ocpwm_mode_t;
   // Fault pins bundle
   typedef struct packed {
      logic comparator;
      logic pin_b;
      logic pin_a;
   } ocpwm_fault_t;
endpackage

// ### ocpwm_channel.sv
// Purpose: One output compare / PWM channel with AHB-Lite registers
// Assumes: Timer ticks and fault levels arrive asynchronous, synced here
// Notes: Single clock domain, no interrupt logic beyond the flag output
// Functional notes
// R01: Period equals period value plus one counts
// R02: Duty values latch only at period match; compare modes load them every cycle
// R03: All zero registers keep output low
// R04: Secondary above period keeps output high
// R05: Idle-stop bit halts channel during idle
// R06: Three-bit field selects counting clock source
// R07: Three enable bits arm each fault input
// R08: Hardware sets status bit on fault
// R09: Fault bits act only in PWM modes
// R10: Comparator fault comes from pair's comparator
// R11: Trigger flag cleared by match or software
// R12: Modes 111 center, 110 edge PWM
// R13: Mode 101 toggles on alternate matches
// R14: Mode 100 produces a single pulse
// R15: Mode 011 toggles on every match
// R16: Mode 010 starts high, falls once
// R17: Mode 001 starts low, rises once
// R18: Mode 000 disables the channel
// R19: Top two control bits read zero
// R20: Interrupt flag on primary or secondary match
// R21: Hold mode keeps fault until software clears
// R22: Fault drives output to chosen level
// R23: Counter advances once per selected tick
`timescale 1ns/1ns
module ocpwm_channel
   import ocpwm_pkg::*;
(
   input wire logic SYS_CLK, // System clock, 25 MHz
   input wire logic SYS_RST, // Synchronous reset, active high
   input wire logic HSEL, // Slave select
   input wire logic [31:0] HADDR, // Address
   input wire logic [1:0] HTRANS, // Transfer type
   input wire logic HWRITE, // Write strobe
   input wire logic [2:0] HSIZE, // Transfer size
   input wire logic [31:0] HWDATA, // Write data
   input wire logic HREADY, // Bus ready in
   output logic [31:0] HRDATA, // Read data
   output logic HREADYOUT, // Slave ready
   output logic HRESP, // Response, always OKAY
   input wire logic [4:0] TIMER_TICK, // Prescaled ticks of timers 2-5 and 1
   input wire logic CPU_IDLE, // Processor idle
   input wire ocpwm_fault_t FAULT_IN, // Fault inputs, high means fault
   output logic CHANNEL_OUTPUT, // Compare / PWM output
   output logic CHANNEL_IRQ_FLAG // Match event flag level
);
   // ********************************
   // Registers and state
   // ********************************
   logic [15:0] compare_control_one;
   logic [15:0] primary_duty_value;
   logic [15:0] secondary_duty_value;
   logic [15:0] period_value;
   logic [15:0] active_primary;
   logic [15:0] active_secondary;
   logic [15:0] channel_counter;
   logic [1:0] fault_aux; // Hold mode and drive level
   logic trigger_running_flag;
   logic [4:0] tick_meta;
   logic [4:0] tick_sync;
   logic [4:0] tick_prev;
   logic [2:0] fault_meta;
   logic [2:0] fault_sync;
   logic idle_meta;
   logic idle_sync;
   logic shot_done;
   logic up_dir;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic tick;
   logic run;
   logic period_match;
   logic prim_match;
   logic sec_match;
   logic pwm_mode;
   logic fault_active;
   logic [2:0] fault_armed;
   logic [2:0] fault_status;
   logic [31:0] next_rdata;
   ocpwm_mode_t mode;
   logic [15:0] wdata;

   assign mode = ocpwm_mode_t'(compare_control_one[2:0]);
   assign fault_status = compare_control_one[POS_ST_CMP:POS_ST_PINA];
   assign wdata = HWDATA[15:0];

   // Word-wide field write helper
   function automatic logic is_write(input logic pend, input logic [7:0] a, input logic [7:0] o);
      is_write = pend && (a == o);
   endfunction

   // PWM mode decode, shared by fault gating and control writes
   function automatic logic is_pwm(input logic [2:0] m);
      is_pwm = (m == OCPWM_EDGE) || (m == OCPWM_CENTER);
   endfunction

   // ********************************
   // Input synchronisers
   // ********************************
   // Two flops on every foreign level
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         tick_meta <= 5'h00;
         tick_sync <= 5'h00;
         tick_prev <= 5'h00;
         fault_meta <= 3'h0;
         fault_sync <= 3'h0;
         idle_meta <= 1'b0;
         idle_sync <= 1'b0;
      end
      else
      begin
         tick_meta <= TIMER_TICK;
         tick_sync <= tick_meta;
         tick_prev <= tick_sync;
         fault_meta <= FAULT_IN; // Comparator input is the pair's comparator, see R10
         fault_sync <= fault_meta;
         idle_meta <= CPU_IDLE;
         idle_sync <= idle_meta;
      end
   end

   // Tick source decode
   always_comb
   begin
      logic [4:0] rise;
      rise = tick_sync & ~tick_prev;
      tick = 1'b0;
      unique case (compare_control_one[POS_TSEL +: 3]) // see R06
         3'h0: tick = rise[0];
         3'h1: tick = rise[1];
         3'h2: tick = rise[2];
         3'h3: tick = rise[3];
         TSEL_T1: tick = rise[4];
         TSEL_FCY: tick = 1'b1;
         default: tick = 1'b0; // Reserved codes do not count
      endcase
   end

   // Halt in idle when asked; off mode does nothing
   assign run = (mode != OCPWM_OFF) && !(compare_control_one[POS_IDLE_STOP] && idle_sync)
      && tick; // see R05, R18, R23
   assign period_match = (channel_counter == period_value);
   assign prim_match = (channel_counter == active_primary);
   assign sec_match = (channel_counter == active_secondary);
   assign pwm_mode = is_pwm(compare_control_one[2:0]);
   assign fault_armed = {compare_control_one[POS_EN_CMP], compare_control_one[POS_EN_PINB],
      compare_control_one[POS_EN_PINA]} & fault_sync & {3{pwm_mode}}; // see R07, R09
   assign fault_active = pwm_mode && ((|fault_armed) || (|fault_status));

   // ********************************
   // Time base
   // ********************************
   // Counter wraps after period value, giving N+1 counts; in center mode it turns back at period value and at zero
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         channel_counter <= 16'h0000;
         up_dir <= 1'b1;
      end
      else if (mode == OCPWM_OFF)
      begin
         channel_counter <= 16'h0000;
         up_dir <= 1'b1;
      end
      else if (run)
      begin
         if (mode == OCPWM_CENTER)
         begin
            if (up_dir && period_match)
               up_dir <= 1'b0;
            else if (!up_dir && channel_counter == 16'h0000)
               up_dir <= 1'b1;
            else
               channel_counter <= up_dir ? channel_counter + 16'h0001
                  : channel_counter - 16'h0001;
         end
         else if (period_match)
            channel_counter <= 16'h0000; // see R01, R23
         else
            channel_counter <= channel_counter + 16'h0001;
      end
   end

   // Duty buffers load at period end, or directly in compare modes
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         active_primary <= 16'h0000;
         active_secondary <= 16'h0000;
      end
      else if (!pwm_mode || (run && period_match && (up_dir || mode != OCPWM_CENTER)))
      begin
         active_primary <= primary_duty_value; // see R02
         active_secondary <= secondary_duty_value;
      end
   end

   // ********************************
   // Output generation
   // ********************************
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         CHANNEL_OUTPUT <= 1'b0;
         shot_done <= 1'b0;
      end
      else if (is_write(wr_pend, wr_addr, OFS_CTRL_ONE))
      begin
         CHANNEL_OUTPUT <= (wdata[2:0] == OCPWM_SS_LOW); // see R16, R17, R13, R14
         shot_done <= 1'b0;
      end
      else if (fault_active)
         CHANNEL_OUTPUT <= fault_aux[POS_DRIVE_LEVEL]; // see R22
      else if (run)
      begin
         unique case (mode)
            OCPWM_OFF: CHANNEL_OUTPUT <= 1'b0; // see R18
            OCPWM_SS_HIGH:
               if (prim_match) CHANNEL_OUTPUT <= 1'b1; // see R17
            OCPWM_SS_LOW:
               if (prim_match) CHANNEL_OUTPUT <= 1'b0; // see R16
            OCPWM_TOGGLE:
               if (prim_match) CHANNEL_OUTPUT <= !CHANNEL_OUTPUT; // see R15
            OCPWM_DBL_SHOT:
               if (!shot_done && prim_match) CHANNEL_OUTPUT <= 1'b1; // see R14
               else if (!shot_done && sec_match && CHANNEL_OUTPUT)
               begin
                  CHANNEL_OUTPUT <= 1'b0;
                  shot_done <= 1'b1;
               end
            OCPWM_DBL_CONT:
               if (prim_match) CHANNEL_OUTPUT <= 1'b1; // see R13
               else if (sec_match) CHANNEL_OUTPUT <= 1'b0;
            OCPWM_EDGE, OCPWM_CENTER:
               // High from primary match to secondary match, see R12
               if (active_secondary > period_value) CHANNEL_OUTPUT <= 1'b1; // see R04
               else if (prim_match && active_primary != active_secondary)
                  CHANNEL_OUTPUT <= 1'b1;
               else if (sec_match) CHANNEL_OUTPUT <= 1'b0; // see R03
         endcase
      end
   end

   // Match event flag
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
         CHANNEL_IRQ_FLAG <= 1'b0;
      else if (run && (mode == OCPWM_SS_HIGH || mode == OCPWM_SS_LOW || mode == OCPWM_TOGGLE))
         CHANNEL_IRQ_FLAG <= prim_match; // see R20
      else if (run && mode != OCPWM_OFF)
         CHANNEL_IRQ_FLAG <= sec_match;
      else
         CHANNEL_IRQ_FLAG <= 1'b0;
   end

   // ********************************
   // Register file
   // ********************************
   // Control one: software fields, hardware fault status, see R08, R21
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
         compare_control_one <= CTRL_ONE_RESET;
      else
      begin
         if (is_write(wr_pend, wr_addr, OFS_CTRL_ONE))
            compare_control_one <= wdata & CTRL_ONE_MASK; // see R19
         for (int i = 0; i < 3; i++)
         begin
            if (fault_armed[i])
               compare_control_one[POS_ST_PINA + i] <= 1'b1; // Set wins over clear
            else if (!fault_aux[POS_HOLD_MODE] && run && period_match)
               compare_control_one[POS_ST_PINA + i] <= 1'b0;
            else if (!pwm_mode || (is_write(wr_pend, wr_addr, OFS_CTRL_ONE)
               && !is_pwm(wdata[2:0])))
               compare_control_one[POS_ST_PINA + i] <= 1'b0; // see R09
         end
      end
   end

   // Duty, period and auxiliary registers
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         primary_duty_value <= 16'h0000;
         secondary_duty_value <= 16'h0000;
         period_value <= 16'h0000;
         fault_aux <= 2'h0;
      end
      else
      begin
         if (is_write(wr_pend, wr_addr, OFS_PRIMARY)) primary_duty_value <= wdata;
         if (is_write(wr_pend, wr_addr, OFS_SECONDARY)) secondary_duty_value <= wdata;
         if (is_write(wr_pend, wr_addr, OFS_PERIOD)) period_value <= wdata;
         if (is_write(wr_pend, wr_addr, OFS_CTRL_AUX)) fault_aux <= wdata[1:0];
      end
   end

   // Trigger flag: set by software, cleared by software or match
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
         trigger_running_flag <= 1'b0;
      else if (is_write(wr_pend, wr_addr, OFS_STATUS))
         trigger_running_flag <= wdata[0];
      else if (compare_control_one[POS_TRIG_MODE] && run && sec_match)
         trigger_running_flag <= 1'b0; // see R11
   end

   // ********************************
   // AHB-Lite slave
   // ********************************
   // Write data follows address phase; zero wait states
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         HRDATA <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE;
         wr_addr <= HADDR[7:0];
         if (HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE)
            HRDATA <= next_rdata;
      end
   end

   // Read mux, unmapped reads return zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (HADDR[7:0])
         OFS_CTRL_ONE: next_rdata = {16'h0000, compare_control_one}; // see R19
         OFS_PRIMARY: next_rdata = {16'h0000, primary_duty_value};
         OFS_SECONDARY: next_rdata = {16'h0000, secondary_duty_value};
         OFS_PERIOD: next_rdata = {16'h0000, period_value};
         OFS_CTRL_AUX: next_rdata = {30'h0000_0000, fault_aux};
         OFS_STATUS: next_rdata = {31'h0000_0000, trigger_running_flag};
         OFS_COUNTER: next_rdata = {16'h0000, channel_counter};
         default: next_rdata = IDENT_VALUE;
      endcase
   end

   // Always ready, always OKAY
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
      else
      begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end
endmodule

// ### ocpwm_channel_asserts.sv
// Purpose: Port-level checks for the compare/PWM channel
// Assumes: Shadow copies follow bus writes, zero wait states
// Notes: Bound into every ocpwm_channel
`timescale 1ns/1ns
module ocpwm_channel_asserts
   import ocpwm_pkg::*;
(
   input wire logic SYS_CLK, // Clock
   input wire logic SYS_RST, // Reset
   input wire logic HSEL, // Select
   input wire logic [31:0] HADDR, // Address
   input wire logic [1:0] HTRANS, // Transfer type
   input wire logic HWRITE, // Write
   input wire logic [2:0] HSIZE, // Size
   input wire logic [31:0] HWDATA, // Write data
   input wire logic HREADY, // Ready in
   input wire logic [31:0] HRDATA, // Read data
   input wire logic HREADYOUT, // Ready out
   input wire logic HRESP, // Response
   input wire logic [4:0] TIMER_TICK, // Ticks
   input wire logic CPU_IDLE, // Idle
   input wire ocpwm_fault_t FAULT_IN, // Faults
   input wire logic CHANNEL_OUTPUT, // Output
   input wire logic CHANNEL_IRQ_FLAG // Match flag
);
   // ****************
   // Shadows and checks
   // ****************
   logic wr_ph, rd_ph, drv, pwm;
   logic [7:0] ad, age;
   logic [15:0] ctl, pri, sec, per;
   assign pwm = ctl[2:1] == 2'h3;
   // Mirror written values; age counts cycles since the last write
   always_ff @(posedge SYS_CLK)
   begin
      age <= (wr_ph && HREADY) ? 8'h00 : age + {7'h00, age != 8'hff};
      if (HREADY)
      begin
         wr_ph <= HSEL && HTRANS == HTRANS_NONSEQ && HWRITE;
         rd_ph <= HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE;
         ad <= HADDR[7:0];
      end
      if (wr_ph && HREADY)
      begin
         case (ad)
            OFS_CTRL_ONE: ctl <= HWDATA[15:0];
            OFS_PRIMARY: pri <= HWDATA[15:0];
            OFS_SECONDARY: sec <= HWDATA[15:0];
            OFS_PERIOD: per <= HWDATA[15:0];
            OFS_CTRL_AUX: drv <= HWDATA[0];
            default: ;
         endcase
      end
      if (SYS_RST)
         {wr_ph, rd_ph, drv, age, ctl, pri, sec, per} <= '0;
   end
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);
   upper_zero_a: assert property (rd_ph |-> HRDATA[31:16] == 16'h0000 &&
      (ad != OFS_CTRL_ONE || HRDATA[15:14] == 2'h0)) else $error("unused read bits set");
   status_idle_a: assert property (rd_ph && ad == OFS_CTRL_ONE && !pwm |->
      HRDATA[6:4] == 3'h0) else $error("fault status outside PWM");
   off_quiet_a: assert property (ctl[2:0] == 3'h0 && age > 8'h03 |->
      !CHANNEL_OUTPUT && !CHANNEL_IRQ_FLAG) else $error("activity while off");
   zero_duty_a: assert property (pwm && {pri, sec, per} == 48'h0 && !drv && age > 8'h08 |->
      !CHANNEL_OUTPUT) else $error("zero duty output high");
   full_duty_a: assert property (ctl[12:0] == 13'h1c06 && sec > per && per < 16'h0010 &&
      age > 8'h28 |-> CHANNEL_OUTPUT) else $error("full duty output low");
   fault_drive_a: assert property ((pwm && ctl[7] && FAULT_IN.pin_a) [*6] |->
      CHANNEL_OUTPUT == drv) else $error("fault level wrong");
   start_low_a: assert property (wr_ph && HREADY && ad == OFS_CTRL_ONE &&
      HWDATA[2:0] inside {3'h1, 3'h4, 3'h5} |-> ##[1:2] !CHANNEL_OUTPUT) else $error("no low start");
   start_high_a: assert property (wr_ph && HREADY && ad == OFS_CTRL_ONE &&
      HWDATA[2:0] == 3'h2 |-> ##[1:2] CHANNEL_OUTPUT) else $error("no high start");
   irq_pulse_a: assert property (CHANNEL_IRQ_FLAG && ctl[2:0] inside {3'h1, 3'h2, 3'h3} &&
      per > 16'h0001 |=> !CHANNEL_IRQ_FLAG) else $error("match flag too long");
   idle_halt_a: assert property ((ctl[13] && CPU_IDLE && age > 8'h02) [*5] |->
      $stable(CHANNEL_OUTPUT) && !CHANNEL_IRQ_FLAG) else $error("channel ran in idle");
   cover property (pwm && CHANNEL_OUTPUT);
   cover property (CHANNEL_IRQ_FLAG);
   cover property (ctl[13] && CPU_IDLE);
endmodule
bind ocpwm_channel ocpwm_channel_asserts chk_u (.SYS_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS,
   .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .TIMER_TICK, .CPU_IDLE,
   .FAULT_IN, .CHANNEL_OUTPUT, .CHANNEL_IRQ_FLAG);

// ### ocpwm_far_model.sv
// Purpose: Far-side model of timer ticks and fault pins
// Assumes: Bench asks for faults as levels
// Notes: Each tick line has its own rate so the source choice shows
`timescale 1ns/1ns
module ocpwm_far_model
   import ocpwm_pkg::*;
(
   input wire logic clk, // Bench clock
   input wire logic [2:0] fault_req, // Requested faults, pin_a lowest
   output ocpwm_fault_t fault_pins, // Fault lines toward the channel
   output logic [4:0] tick // Prescaled timer outputs
);
   // ****************
   // Timers and pins
   // ****************
   int cnt [5] = '{default: 0};
   logic [4:0] ph = 5'h00; // Tick line levels, one driver each
   assign tick = ph;
   // Line i toggles every i+2 clocks, a rising edge every 2*(i+2)
   always @(posedge clk)
   begin
      for (int i = 0; i < 5; i++)
      begin
         cnt[i] <= (cnt[i] == i + 1) ? 0 : cnt[i] + 1;
         ph[i] <= ph[i] ^ (cnt[i] == i + 1);
      end
   end
   // Comparator of this channel pair drives the third line
   always @(posedge clk)
      fault_pins <= fault_req;
endmodule

// ### ocpwm_channel_tb.sv
// Purpose: Self-checking bench for the compare/PWM channel
// Assumes: Bus answers with zero wait states
// Notes: Ticks and fault pins come from the far-side model
`timescale 1ns/1ns
module ocpwm_channel_tb
   import ocpwm_pkg::*;
   ;
   // ****************
   // Bench
   // ****************
   logic sys_clk, sys_rst, hsel, hwrite, cpu_idle, hreadyout, hresp, chan_out, irq_flag;
   logic [31:0] haddr, hwdata, hrdata, qa, qb;
   logic [1:0] htrans;
   logic [2:0] hsize, fault_req;
   logic [4:0] tick;
   ocpwm_fault_t fault;
   int n_errors = 0, total_checks = 0;
   int mn [8] = '{0, 1, 1, 4, 2, 8, 8, 4};
   int mx [8] = '{0, 1, 1, 9, 2, 17, 17, 17};
   int fin [8] = '{0, 1, 0, 2, 0, 2, 2, 2};
   ocpwm_channel dut_u (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TIMER_TICK(tick),
      .CPU_IDLE(cpu_idle), .FAULT_IN(fault), .CHANNEL_OUTPUT(chan_out),
      .CHANNEL_IRQ_FLAG(irq_flag));
   ocpwm_far_model far_u (.clk(sys_clk), .fault_req(fault_req), .fault_pins(fault), .tick(tick));
   // 25 MHz clock
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One single word transfer; entered just after a clock edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {16'h0000, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      cmp(q, e);
      cmp({31'h0, hresp}, 32'h0);
   endtask
   function automatic logic [31:0] o();
      return {31'h0, chan_out};
   endfunction
   // Wait for a rising edge of the channel output
   task automatic rise();
      logic p;
      p = 1'b1;
      repeat (400)
      begin
         @(posedge sys_clk);
         if (chan_out === 1'b1 && p === 1'b0)
            return;
         p = chan_out;
      end
   endtask
   task automatic report_and_stop();
      $display("Checks made: %0d, mismatches: %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      int t0, e, f;
      logic p;
      {hsel, hwrite, cpu_idle, fault_req, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      sys_rst = 1'b1;
      cyc(10);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         chk(8'(4 * i), 32'h0);
      wr(OFS_CTRL_ONE, 16'hff8f);
      chk(OFS_CTRL_ONE, 32'h3f8f);
      wr(OFS_PERIOD, 16'h0007);
      wr(OFS_PRIMARY, 16'h0002);
      wr(OFS_SECONDARY, 16'h0005);
      for (int i = 0; i < 6; i++)
      begin
         wr(OFS_CTRL_ONE, {3'h0, (i == 5) ? 3'h7 : 3'(i), 7'h00, 3'h6});
         rise();
         rise();
         t0 = int'($time);
         rise();
         cmp(32'((int'($time) - t0) / 40), (i == 5) ? 32'h8 : 32'(16 * (i + 2)));
      end
      wr(OFS_CTRL_ONE, 16'h0000);
      wr(OFS_PERIOD, 16'h0000);
      wr(OFS_PRIMARY, 16'h0000);
      wr(OFS_SECONDARY, 16'h0000);
      wr(OFS_CTRL_ONE, 16'h1c06);
      cyc(20);
      cmp(o(), 32'h0);
      wr(OFS_PERIOD, 16'h0007);
      wr(OFS_SECONDARY, 16'h0020);
      cyc(48);
      cmp(o(), 32'h1);
      wr(OFS_SECONDARY, 16'h0005);
      wr(OFS_CTRL_AUX, 16'h0001);
      for (int j = 0; j < 3; j++)
      begin
         wr(OFS_CTRL_ONE, 16'h1c06 | (16'h0080 << j));
         fault_req <= 3'h1 << j;
         cyc(10);
         cmp(o(), 32'h1);
         chk(OFS_CTRL_ONE, 32'h1c06 | (32'h90 << j));
         fault_req <= 3'h0;
         cyc(20);
         chk(OFS_CTRL_ONE, 32'h1c06 | (32'h80 << j));
      end
      wr(OFS_CTRL_ONE, 16'h1c06);
      fault_req <= 3'h7;
      cyc(10);
      chk(OFS_CTRL_ONE, 32'h1c06);
      fault_req <= 3'h0;
      wr(OFS_CTRL_AUX, 16'h0002);
      wr(OFS_CTRL_ONE, 16'h1c86);
      fault_req <= 3'h1;
      cyc(10);
      cmp(o(), 32'h0);
      fault_req <= 3'h0;
      cyc(20);
      chk(OFS_CTRL_ONE, 32'h1c96);
      wr(OFS_CTRL_ONE, 16'h1c86);
      chk(OFS_CTRL_ONE, 32'h1c86);
      wr(OFS_CTRL_AUX, 16'h0000);
      wr(OFS_CTRL_ONE, 16'h3c06);
      cpu_idle <= 1'b1;
      cyc(6);
      bus(1'b0, OFS_COUNTER, 16'h0000, qa);
      cyc(3);
      chk(OFS_COUNTER, qa);
      wr(OFS_CTRL_ONE, 16'h1c06);
      bus(1'b0, OFS_COUNTER, 16'h0000, qa);
      cyc(3);
      bus(1'b0, OFS_COUNTER, 16'h0000, qb);
      cmp({31'h0, qa !== qb}, 32'h1);
      cpu_idle <= 1'b0;
      wr(OFS_STATUS, 16'h0001);
      cyc(20);
      chk(OFS_STATUS, 32'h1);
      wr(OFS_CTRL_ONE, 16'h1c0e);
      wr(OFS_STATUS, 16'h0001);
      cyc(20);
      chk(OFS_STATUS, 32'h0);
      wr(OFS_PRIMARY, 16'h0004);
      for (int m = 0; m < 8; m++)
      begin
         wr(OFS_CTRL_ONE, 16'h1c00);
         cyc(4);
         wr(OFS_CTRL_ONE, 16'h1c00 | 16'(m));
         cyc(2);
         e = 0;
         f = 0;
         p = chan_out;
         repeat (64)
         begin
            @(posedge sys_clk);
            e += int'(chan_out !== p);
            f += int'(irq_flag === 1'b1);
            p = chan_out;
         end
         cmp({31'h0, e >= mn[m] && e <= mx[m]}, 32'h1);
         cmp({31'h0, f > 0}, {31'h0, m != 0});
         if (fin[m] < 2)
            cmp(o(), 32'(fin[m]));
      end
      report_and_stop();
   end
   // Watchdog against a hung wait
   initial
   begin
      cyc(30000);
      n_errors++;
      report_and_stop();
   end
endmodule
